// file: rtl/ebr_pkg.sv
package block_ram_pkg;

    // ----------------------------------------------------------------
    // Array geometry
    // ----------------------------------------------------------------
    localparam int ARRAY_BITS = 9216;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 13;
    localparam int PTR_W = 14;
    localparam int BASE_W = 14;
    localparam int PRELOAD_ADDR_W = 9;
    localparam int STAGE_DEPTH = 16;
    localparam int STAGE_PTR_W = 4;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [DATA_W-1:0] LATCH_RESET = 18'h00000;
    localparam logic [PTR_W-1:0] PTR_RESET = 14'h0000;
    localparam logic [ADDR_W-1:0] ADDR_RESET = 13'h0000;

    // ----------------------------------------------------------------
    // Modes and shapes
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        MODE_SINGLE = 3'b000,
        MODE_TRUE_DUAL = 3'b001,
        MODE_PSEUDO_DUAL = 3'b010,
        MODE_ROM = 3'b011,
        MODE_FIFO = 3'b100
    } mem_mode_type;

    typedef enum logic [2:0] {
        SHAPE_X1 = 3'b000,
        SHAPE_X2 = 3'b001,
        SHAPE_X4 = 3'b010,
        SHAPE_X9 = 3'b011,
        SHAPE_X18 = 3'b100
    } shape_type;

    // Wide shape exists only in pseudo dual-port and FIFO modes.
    function automatic shape_type legal_shape(input mem_mode_type m,
                                              input shape_type s);
        if (s == SHAPE_X18 && m != MODE_PSEUDO_DUAL && m != MODE_FIFO)
            return SHAPE_X9;
        return s;
    endfunction

    function automatic logic [4:0] shape_width(input shape_type s);
        unique case (s)
            SHAPE_X1: return 5'h01;
            SHAPE_X2: return 5'h02;
            SHAPE_X4: return 5'h04;
            SHAPE_X9: return 5'h09;
            SHAPE_X18: return 5'h12;
            default: return 5'h01;
        endcase
    endfunction

    function automatic logic [PTR_W-1:0] shape_depth(input shape_type s);
        unique case (s)
            SHAPE_X1: return 14'h2000;
            SHAPE_X2: return 14'h1000;
            SHAPE_X4: return 14'h0800;
            SHAPE_X9: return 14'h0400;
            SHAPE_X18: return 14'h0200;
            default: return 14'h2000;
        endcase
    endfunction

    // First array bit of a word: words are packed from bit zero upward.
    function automatic logic [BASE_W-1:0] word_base(
        input logic [ADDR_W-1:0] addr, input logic [4:0] w);
        logic [BASE_W+4:0] prod;
        prod = {5'h00, 1'b0, addr} * {14'h0000, w};
        return prod[BASE_W-1:0];
    endfunction

endpackage

// file: rtl/stage_fifo.sv
`timescale 1ns/100ps
module stage_fifo
    import block_ram_pkg::*;
#(
    parameter int WIDTH = DATA_W,
    parameter int DEPTH = STAGE_DEPTH,
    parameter int PW = STAGE_PTR_W
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);

    logic [WIDTH-1:0] slot_r [DEPTH];
    logic [PW-1:0] wp_r;
    logic [PW-1:0] rp_r;
    logic [PW:0] cnt_r;
    logic [PW:0] cnt_nxt;
    logic in_ready_r;
    wire push = in_valid && in_ready_r;
    wire pop = out_valid && out_ready;

    assign cnt_nxt = cnt_r + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
    assign in_ready = in_ready_r;
    assign out_valid = (cnt_r != '0);
    assign out_data = slot_r[rp_r];

    always_ff @(posedge clk) begin
        if (push) begin
            slot_r[wp_r] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b0;
        end else if (flush) begin
            wp_r <= '0;
            rp_r <= '0;
            cnt_r <= '0;
            in_ready_r <= 1'b1;
        end else begin
            wp_r <= wp_r + PW'(push);
            rp_r <= rp_r + PW'(pop);
            cnt_r <= cnt_nxt;
            in_ready_r <= (cnt_nxt < (PW+1)'(DEPTH));
        end
    end

endmodule // stage_fifo

// file: rtl/embedded_block_ram.sv
`timescale 1ns/100ps
// Operation
// - Shapes 8192x1 to 1024x9; x18 pseudo dual/FIFO only.
// - Each port picks its own width; in FIFO mode port B uses port A's.
// - Words packed upward from bit zero, all ports.
// - Contents may be preloaded at configuration.
// - Preloaded with writes disabled acts as ROM.
// - Write data and addresses registered at array.
// - Read data direct or via optional register.
// - Rewind resets only the FIFO read pointer.
// - Output latch reset selectable sync or async.
// - Each latch clear resets only its port.
// - Chip-wide clear resets both port latches.
// - Chip-wide clear always acts asynchronously.
// - FIFO: chip-wide clear always on; enables gate.
// - FIFO clear and rewind reset pointers asynchronously.
// - FIFO uses dedicated pointers and status flags.
module embedded_block_ram
    import block_ram_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Configuration
    input wire mem_mode_type mem_mode,
    input wire shape_type shape_a,
    input wire shape_type shape_b,
    input wire logic out_reg_en,
    input wire logic latch_async_clear,
    // Resets
    input wire logic chip_wide_clear_n,
    input wire logic port_a_latch_clear,
    input wire logic port_b_latch_clear,
    // Configuration preload
    input wire logic preload_en,
    input wire logic [PRELOAD_ADDR_W-1:0] preload_addr,
    input wire logic [DATA_W-1:0] preload_data,
    // Port A
    input wire logic a_ce,
    input wire logic a_we,
    input wire logic [ADDR_W-1:0] a_addr,
    input wire logic [DATA_W-1:0] a_wdata,
    output logic [DATA_W-1:0] a_rdata,
    // Port B
    input wire logic b_ce,
    input wire logic b_we,
    input wire logic [ADDR_W-1:0] b_addr,
    input wire logic [DATA_W-1:0] b_wdata,
    output logic [DATA_W-1:0] b_rdata,
    // FIFO
    input wire logic fifo_clear,
    input wire logic pointer_rewind,
    input wire logic push_valid,
    input wire logic [DATA_W-1:0] push_data,
    output logic push_ready,
    input wire logic fetch_side_enable,
    output logic fifo_empty,
    output logic fifo_full
);

    // ----------------------------------------------------------------
    // Shape and mode decode
    // ----------------------------------------------------------------
    wire is_fifo = (mem_mode == MODE_FIFO);
    wire is_rom = (mem_mode == MODE_ROM);
    wire b_active = (mem_mode == MODE_TRUE_DUAL) ||
                    (mem_mode == MODE_PSEUDO_DUAL);
    wire b_may_write = (mem_mode == MODE_TRUE_DUAL);
    wire shape_type eff_a = legal_shape(mem_mode, shape_a);
    wire shape_type eff_b = legal_shape(mem_mode, shape_b);
    wire [4:0] width_a = shape_width(eff_a);
    wire [4:0] width_b = is_fifo ? width_a : shape_width(eff_b);
    wire [PTR_W-1:0] depth_a = shape_depth(eff_a);
    wire a_user_wr = a_ce && a_we && !is_rom && !is_fifo;
    wire b_user_wr = b_ce && b_we && b_may_write;

    // ----------------------------------------------------------------
    // Storage and input registers
    // ----------------------------------------------------------------
    logic [ARRAY_BITS-1:0] mem_r;
    logic wa_en_r;
    logic [ADDR_W-1:0] wa_addr_r;
    logic [DATA_W-1:0] wa_data_r;
    logic wb_en_r;
    logic [ADDR_W-1:0] wb_addr_r;
    logic [DATA_W-1:0] wb_data_r;
    logic ra_en_r;
    logic [ADDR_W-1:0] ra_addr_r;
    logic rb_en_r;
    logic [ADDR_W-1:0] rb_addr_r;
    logic pa_vld_r;
    logic pb_vld_r;
    logic [DATA_W-1:0] pipe_a_r;
    logic [DATA_W-1:0] pipe_b_r;
    logic [DATA_W-1:0] out_a_r;
    logic [DATA_W-1:0] out_b_r;
    logic [PTR_W-1:0] wr_ptr_r;
    logic [PTR_W-1:0] rd_ptr_r;
    logic empty_r;
    logic full_r;

    // ----------------------------------------------------------------
    // FIFO write staging
    // ----------------------------------------------------------------
    logic stage_valid;
    logic [DATA_W-1:0] stage_data;
    wire [PTR_W-1:0] fill = wr_ptr_r - rd_ptr_r;
    wire arr_full = (fill >= depth_a);
    wire arr_empty = (fill == PTR_RESET);
    wire drain = is_fifo && stage_valid && !arr_full;
    wire fetch = is_fifo && fetch_side_enable && !arr_empty;
    wire [PTR_W-1:0] mask_a = depth_a - 14'h0001;
    wire [PTR_W-1:0] wr_idx = wr_ptr_r & mask_a;
    wire [PTR_W-1:0] rd_idx = rd_ptr_r & mask_a;

    stage_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(STAGE_DEPTH),
        .PW(STAGE_PTR_W)
    ) u_stage (
        .clk(ref_clk),
        .rstn(rstn),
        .flush(fifo_clear),
        .in_valid(push_valid && is_fifo),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(stage_valid),
        .out_ready(drain),
        .out_data(stage_data)
    );

    // Write requests are captured on the port's enabled edge.
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wa_en_r <= 1'b0;
            wa_addr_r <= ADDR_RESET;
            wa_data_r <= LATCH_RESET;
            wb_en_r <= 1'b0;
            wb_addr_r <= ADDR_RESET;
            wb_data_r <= LATCH_RESET;
        end else begin
            wa_en_r <= a_user_wr || drain;
            wb_en_r <= b_user_wr;
            if (a_user_wr || drain) begin
                wa_addr_r <= drain ? wr_idx[ADDR_W-1:0] : a_addr;
                wa_data_r <= drain ? stage_data : a_wdata;
            end
            if (b_user_wr) begin
                wb_addr_r <= b_addr;
                wb_data_r <= b_wdata;
            end
        end
    end

    // Read addresses are captured on the port's enabled edge.
    wire a_rd_req = a_ce && !a_we && !is_fifo;
    wire b_rd_req = (b_ce && b_active && !(b_we && b_may_write)) || fetch;
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ra_en_r <= 1'b0;
            ra_addr_r <= ADDR_RESET;
            rb_en_r <= 1'b0;
            rb_addr_r <= ADDR_RESET;
        end else begin
            ra_en_r <= a_rd_req;
            rb_en_r <= b_rd_req;
            if (a_rd_req) begin
                ra_addr_r <= a_addr;
            end
            if (b_rd_req) begin
                rb_addr_r <= fetch ? rd_idx[ADDR_W-1:0] : b_addr;
            end
        end
    end

    wire [BASE_W-1:0] wa_base = word_base(wa_addr_r, width_a);
    wire [BASE_W-1:0] wb_base = word_base(wb_addr_r, width_b);
    wire [BASE_W-1:0] ra_base = word_base(ra_addr_r, width_a);
    wire [BASE_W-1:0] rb_base = word_base(rb_addr_r, width_b);
    wire [BASE_W-1:0] pl_base = word_base({4'h0, preload_addr}, 5'h12);

    // Port B is applied after port A at each index k; on a shared bit the later k wins.
    always_ff @(posedge ref_clk) begin
        for (int k = 0; k < DATA_W; k++) begin
            if (preload_en && (int'(pl_base) + k < ARRAY_BITS)) begin
                mem_r[int'(pl_base) + k] <= preload_data[k];
            end
            if (wa_en_r && k < int'(width_a) &&
                int'(wa_base) + k < ARRAY_BITS) begin
                mem_r[int'(wa_base) + k] <= wa_data_r[k];
            end
            if (wb_en_r && k < int'(width_b) &&
                int'(wb_base) + k < ARRAY_BITS) begin
                mem_r[int'(wb_base) + k] <= wb_data_r[k];
            end
        end
    end

    // ----------------------------------------------------------------
    // Array read and output latches
    // ----------------------------------------------------------------
    logic [DATA_W-1:0] read_a;
    logic [DATA_W-1:0] read_b;
    always_comb begin
        read_a = LATCH_RESET;
        read_b = LATCH_RESET;
        for (int k = 0; k < DATA_W; k++) begin
            if (k < int'(width_a) && int'(ra_base) + k < ARRAY_BITS)
                read_a[k] = mem_r[int'(ra_base) + k];
            if (k < int'(width_b) && int'(rb_base) + k < ARRAY_BITS)
                read_b[k] = mem_r[int'(rb_base) + k];
        end
    end

    wire clr_a_async = !chip_wide_clear_n ||
                       (latch_async_clear && port_a_latch_clear);
    wire clr_b_async = !chip_wide_clear_n ||
                       (latch_async_clear && port_b_latch_clear);
    wire aclr_a_n = rstn && !clr_a_async;
    wire aclr_b_n = rstn && !clr_b_async;
    wire sclr_a = !latch_async_clear && port_a_latch_clear;
    wire sclr_b = !latch_async_clear && port_b_latch_clear;

    always_ff @(posedge ref_clk or negedge aclr_a_n) begin
        if (!aclr_a_n) begin
            pipe_a_r <= LATCH_RESET;
            out_a_r <= LATCH_RESET;
            pa_vld_r <= 1'b0;
        end else if (sclr_a) begin
            pipe_a_r <= LATCH_RESET;
            out_a_r <= LATCH_RESET;
            pa_vld_r <= 1'b0;
        end else begin
            pa_vld_r <= ra_en_r;
            if (ra_en_r) begin
                pipe_a_r <= read_a;
            end
            if (out_reg_en ? pa_vld_r : ra_en_r) begin
                out_a_r <= out_reg_en ? pipe_a_r : read_a;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge aclr_b_n) begin
        if (!aclr_b_n) begin
            pipe_b_r <= LATCH_RESET;
            out_b_r <= LATCH_RESET;
            pb_vld_r <= 1'b0;
        end else if (sclr_b) begin
            pipe_b_r <= LATCH_RESET;
            out_b_r <= LATCH_RESET;
            pb_vld_r <= 1'b0;
        end else begin
            pb_vld_r <= rb_en_r;
            if (rb_en_r) begin
                pipe_b_r <= read_b;
            end
            if (out_reg_en ? pb_vld_r : rb_en_r) begin
                out_b_r <= out_reg_en ? pipe_b_r : read_b;
            end
        end
    end

    assign a_rdata = out_a_r;
    assign b_rdata = out_b_r;

    // ----------------------------------------------------------------
    // FIFO pointers and flags
    // ----------------------------------------------------------------
    wire fclr_n = rstn && !(is_fifo && (!chip_wide_clear_n || fifo_clear));
    wire rclr_n = fclr_n && !(is_fifo && pointer_rewind);

    always_ff @(posedge ref_clk or negedge fclr_n) begin
        if (!fclr_n) begin
            wr_ptr_r <= PTR_RESET;
        end else if (drain) begin
            wr_ptr_r <= wr_ptr_r + 14'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge rclr_n) begin
        if (!rclr_n) begin
            rd_ptr_r <= PTR_RESET;
        end else if (fetch) begin
            rd_ptr_r <= rd_ptr_r + 14'h0001;
        end
    end

    wire [PTR_W-1:0] fill_nxt = (wr_ptr_r + PTR_W'(drain)) -
                                (rd_ptr_r + PTR_W'(fetch));
    always_ff @(posedge ref_clk or negedge fclr_n) begin
        if (!fclr_n) begin
            empty_r <= 1'b1;
            full_r <= 1'b0;
        end else begin
            empty_r <= (fill_nxt == PTR_RESET);
            full_r <= (fill_nxt >= depth_a);
        end
    end

    assign fifo_empty = empty_r;
    assign fifo_full = full_r;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence s_user_write;
        a_ce && a_we && !is_rom && !is_fifo;
    endsequence

    sequence s_captured;
        wa_en_r && (wa_addr_r == $past(a_addr)) &&
        (wa_data_r == $past(a_wdata));
    endsequence

    chk_input_capture: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        s_user_write |=> s_captured)
        else $error("port A write not captured at array input");

    chk_rom_write_block: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (is_rom && a_ce && a_we && !(b_ce && b_we && b_may_write)) |=>
        !wa_en_r && !wb_en_r)
        else $error("write reached array in read-only mode");

    chk_bypass_read: assert property (
        @(posedge ref_clk) disable iff (!aclr_a_n)
        (!out_reg_en && ra_en_r && !sclr_a) ##1 (!out_reg_en && aclr_a_n)
        |-> out_a_r == $past(read_a))
        else $error("unregistered read data wrong");

    chk_oreg_delay: assert property (
        @(posedge ref_clk) disable iff (!aclr_a_n)
        (out_reg_en && ra_en_r && !sclr_a) ##1 (out_reg_en && !sclr_a)
        ##1 out_reg_en |-> out_a_r == $past(read_a, 2))
        else $error("registered read data wrong");

    chk_rewind_only_rd: assert property (
        @(posedge ref_clk) disable iff (!fclr_n)
        (is_fifo && pointer_rewind && !drain) |->
        rd_ptr_r == PTR_RESET ##1 wr_ptr_r == $past(wr_ptr_r))
        else $error("rewind disturbed write pointer or missed read");

    chk_port_a_clear: assert property (
        @(posedge ref_clk) disable iff (!rstn || !chip_wide_clear_n)
        (sclr_a && !port_b_latch_clear && !rb_en_r && !pb_vld_r) |=>
        out_a_r == LATCH_RESET && $stable(out_b_r))
        else $error("port A clear wrong or leaked to port B");

    chk_chip_clear: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        !chip_wide_clear_n |->
        out_a_r == LATCH_RESET && out_b_r == LATCH_RESET)
        else $error("chip-wide clear left a latch set");

    chk_fifo_clear: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (is_fifo && fifo_clear) |->
        wr_ptr_r == PTR_RESET && rd_ptr_r == PTR_RESET)
        else $error("FIFO clear did not reset pointers");

    chk_full_hold: assert property (
        @(posedge ref_clk) disable iff (!fclr_n)
        (is_fifo && arr_full) |=> wr_ptr_r == $past(wr_ptr_r))
        else $error("write pointer advanced while full");

    chk_port_b_idle: assert property (
        @(posedge ref_clk) disable iff (!rstn)
        (!b_ce && !fetch) |=> !rb_en_r && !wb_en_r && $stable(rb_addr_r))
        else $error("port B moved without its enable");

endmodule // embedded_block_ram

// file: sim/user_core_model.sv
`timescale 1ns/100ps
// ----------------------------------------------------------------
// Core logic that sequences a clear against the enables
// ----------------------------------------------------------------
module user_core_model (
    // Clock
    input wire logic ref_clk,
    // Control
    input wire logic go,
    output logic hold_en,
    output logic clear_out
);
    initial begin
        hold_en = 1'b0;
        clear_out = 1'b0;
        forever begin
            @(posedge ref_clk);
            if (go) begin
                #1 hold_en = 1'b1;
                @(posedge ref_clk);
                #1 clear_out = 1'b1;
                @(posedge ref_clk);
                #1 clear_out = 1'b0;
                @(posedge ref_clk);
                #1 hold_en = 1'b0;
            end
        end
    end
endmodule // user_core_model

// file: sim/embedded_block_ram_tb.sv
`timescale 1ns/100ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
    $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module embedded_block_ram_tb;
    import block_ram_pkg::*;
    logic ref_clk, rstn, out_reg_en, latch_async_clear;
    mem_mode_type mem_mode;
    shape_type shape_a, shape_b;
    logic a_ce_d, a_we, b_ce_d, b_we, push_d, fetch_d, go, hold_en;
    logic clear_out, preload_en, port_a_latch_clear, port_b_latch_clear;
    logic [PRELOAD_ADDR_W-1:0] preload_addr;
    logic [ADDR_W-1:0] a_addr, b_addr;
    logic [DATA_W-1:0] a_wdata, b_wdata, push_data, preload_data;
    logic [DATA_W-1:0] a_rdata, b_rdata;
    logic [1:0] sel;
    logic push_ready, fifo_empty, fifo_full;
    int bad_count, checked, cycles, i;
    wire a_ce = a_ce_d & ~hold_en;
    wire b_ce = b_ce_d & ~hold_en;
    wire push_valid = push_d & ~hold_en;
    wire fetch_side_enable = fetch_d & ~hold_en;
    wire chip_wide_clear_n = ~(clear_out & (sel == 2'h0));
    wire fifo_clear = clear_out & (sel == 2'h1);
    wire pointer_rewind = clear_out & (sel == 2'h2);

    embedded_block_ram u_dut (.ref_clk, .rstn, .mem_mode, .shape_a,
        .shape_b, .out_reg_en, .latch_async_clear, .chip_wide_clear_n,
        .port_a_latch_clear, .port_b_latch_clear, .preload_en,
        .preload_addr, .preload_data, .a_ce, .a_we, .a_addr, .a_wdata,
        .a_rdata, .b_ce, .b_we, .b_addr, .b_wdata, .b_rdata, .fifo_clear,
        .pointer_rewind, .push_valid, .push_data, .push_ready,
        .fetch_side_enable, .fifo_empty, .fifo_full);

    user_core_model u_core (.ref_clk(ref_clk), .go(go), .hold_en(hold_en),
        .clear_out(clear_out));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    task automatic end_sim();
        if (bad_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 5000) begin
            bad_count++;
            $display("[ERR] %0t timeout", $time);
            end_sim();
        end
    end

    task automatic tick();
        @(posedge ref_clk);
        #1;
    endtask

    // One port access; a read waits for the output latch.
    task automatic acc(input logic pb, input logic w,
                       input logic [ADDR_W-1:0] ad,
                       input logic [DATA_W-1:0] d);
        if (pb) begin
            b_ce_d = 1'b1; b_we = w; b_addr = ad; b_wdata = d;
        end else begin
            a_ce_d = 1'b1; a_we = w; a_addr = ad; a_wdata = d;
        end
        tick();
        a_ce_d = 1'b0; b_ce_d = 1'b0; a_we = 1'b0; b_we = 1'b0;
        tick();
        if (!w && out_reg_en) tick();
    endtask

    // Asks the core model for a sequenced clear; returns inside it.
    task automatic clr(input logic [1:0] s);
        sel = s; go = 1'b1;
        tick();
        go = 1'b0;
        @(posedge clear_out);
        #1;
    endtask

    task automatic push(input logic [DATA_W-1:0] d);
        push_d = 1'b1; push_data = d;
        while (push_ready !== 1'b1) tick();
        tick();
    endtask

    task automatic fetch(input logic [DATA_W-1:0] e);
        fetch_d = 1'b1;
        tick();
        fetch_d = 1'b0;
        tick();
        `CHK(b_rdata, e)
    endtask

    initial begin
        {rstn, out_reg_en, latch_async_clear, a_ce_d, a_we, b_ce_d} = '0;
        {b_we, push_d, fetch_d, go, preload_en, sel} = '0;
        {port_a_latch_clear, port_b_latch_clear, preload_addr} = '0;
        {a_addr, b_addr, a_wdata, b_wdata, push_data, preload_data} = '0;
        {bad_count, checked, cycles} = '0;
        mem_mode = MODE_SINGLE; shape_a = SHAPE_X9; shape_b = SHAPE_X9;
        repeat (10) @(posedge ref_clk);
        #1 rstn = 1'b1;
        `CHK(fifo_empty, 1'b1)
        `CHK(a_rdata, LATCH_RESET)
        tick(); tick();
        `CHK(push_ready, 1'b1)
        acc(0, 1, 5, 18'h001A5); acc(0, 1, 6, 18'h000C3);
        acc(0, 0, 5, 0);
        `CHK(a_rdata, 18'h001A5)
        out_reg_en = 1'b1; acc(0, 0, 6, 0);
        `CHK(a_rdata, 18'h000C3)
        tick(); out_reg_en = 1'b0;
        shape_a = SHAPE_X18; acc(0, 1, 1, 18'h3FFFF); acc(0, 0, 1, 0);
        `CHK(a_rdata, 18'h001FF)
        mem_mode = MODE_TRUE_DUAL; shape_a = SHAPE_X9; shape_b = SHAPE_X1;
        acc(0, 1, 0, 18'h000A5); acc(0, 1, 1, 18'h0013C);
        for (i = 0; i < 18; i++) begin
            acc(1, 0, i[ADDR_W-1:0], 0);
            `CHK(b_rdata, (18'h278A5 >> i) & 18'h1)
        end
        acc(1, 1, 0, 0); acc(0, 0, 0, 0);
        `CHK(a_rdata, 18'h000A4)
        mem_mode = MODE_PSEUDO_DUAL; shape_a = SHAPE_X18; shape_b = SHAPE_X18;
        acc(0, 1, 2, 18'h2B4C7); acc(1, 0, 2, 0); acc(0, 0, 2, 0);
        `CHK(b_rdata, 18'h2B4C7)
        port_a_latch_clear = 1'b1; tick(); port_a_latch_clear = 1'b0;
        `CHK(a_rdata, LATCH_RESET)
        `CHK(b_rdata, 18'h2B4C7)
        acc(0, 0, 2, 0);
        latch_async_clear = 1'b1; port_b_latch_clear = 1'b1; #1;
        `CHK(b_rdata, LATCH_RESET)
        `CHK(a_rdata, 18'h2B4C7)
        tick(); port_b_latch_clear = 1'b0; latch_async_clear = 1'b0;
        acc(1, 0, 2, 0);
        clr(2'h0);
        `CHK(a_rdata, LATCH_RESET)
        `CHK(b_rdata, LATCH_RESET)
        repeat (3) tick();
        mem_mode = MODE_ROM; shape_a = SHAPE_X9;
        preload_en = 1'b1; preload_data = 18'h15A5A; tick(); preload_en = 1'b0;
        acc(0, 1, 0, 18'h001FF); acc(0, 0, 0, 0);
        `CHK(a_rdata, 18'h0005A)
        mem_mode = MODE_FIFO; shape_a = SHAPE_X18;
        clr(2'h1); repeat (3) tick();
        for (i = 0; i < 3; i++) push(18'h10000 + 18'(i));
        push_d = 1'b0; tick();
        `CHK(fifo_empty, 1'b0)
        fetch(18'h10000); fetch(18'h10001);
        clr(2'h2);
        `CHK(fifo_empty, 1'b0)
        repeat (3) tick();
        fetch(18'h10000);
        i = 0; push_d = 1'b1;
        while (push_ready === 1'b1 && i < 600) begin
            tick(); i++;
        end
        push_d = 1'b0; tick();
        `CHK(fifo_full, 1'b1)
        `CHK(push_ready, 1'b0)
        clr(2'h1);
        `CHK(fifo_empty, 1'b1)
        `CHK(fifo_full, 1'b0)
        repeat (3) tick();
        end_sim();
    end
endmodule // embedded_block_ram_tb
